// [src/rx_chain_pkg.sv]
// Package: register map, field layout, reset values and types of the receive baseband
package rx_chain_pkg;
  localparam logic [7:0] ADDR_CHANNEL_FILTER_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_MODULATION_CONFIG = 8'h04;
  localparam logic [7:0] ADDR_ONOFF_SLICER_CONFIG = 8'h08;
  localparam logic [7:0] ADDR_SIGNAL_STRENGTH_LIMIT = 8'h0C;
  localparam logic [7:0] ADDR_SIGNAL_STRENGTH_READING = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_BIT_PERIOD = 8'h18;
  localparam logic [7:0] ADDR_COEF_BASE = 8'h40;
  localparam int NUM_TAPS = 16;
  localparam int DECIM_LEN = 16;
  localparam int SAMPLE_W = 12;
  localparam int COEF_W = 12;
  // Field positions
  localparam int CFC_EXP_LSB = 0;
  localparam int CFC_MANT_LSB = 3;
  localparam int CFC_DCC_LSB = 5;
  localparam int OSC_FLOOR_LSB = 0;
  localparam int OSC_STEP_LSB = 8;
  localparam int OSC_INTERVAL_LSB = 11;
  localparam int OSC_KIND_LSB = 14;
  // Reset values
  localparam logic [7:0] CHANNEL_FILTER_CONFIG_RST = 8'h55;
  localparam logic [1:0] MODULATION_CONFIG_RST = 2'h0;
  localparam logic [15:0] ONOFF_SLICER_CONFIG_RST = 16'h4006;
  localparam logic [7:0] SIGNAL_STRENGTH_LIMIT_RST = 8'hE4;
  localparam logic [15:0] BIT_PERIOD_RST = 16'h0100;
  localparam logic [COEF_W-1:0] COEF_RST = 12'h080;
  // Codes
  localparam logic [1:0] MOD_FSK = 2'h0;
  localparam logic [1:0] MOD_OOK = 2'h1;
  localparam logic [4:0] MANT16 = 5'h10;
  localparam logic [4:0] MANT20 = 5'h14;
  localparam logic [4:0] MANT24 = 5'h18;
  localparam logic [3:0] EXP_OFFSET_FSK = 4'h2;
  localparam logic [3:0] EXP_OFFSET_OOK = 4'h3;
  localparam logic [3:0] DCC_SHIFT_BASE = 4'h3;
  localparam logic [7:0] PEAK_DROP_6DB = 8'h0C;
  localparam int RSSI_ACQ_BITS = 2;
  typedef enum logic [1:0] {KIND_FIXED, KIND_PEAK, KIND_AVERAGE, KIND_RSVD} onoff_kind_e;
  typedef enum {CAL_IDLE, CAL_INJECT, CAL_DONE} cal_state_e;
  typedef struct packed {
    logic signed [SAMPLE_W-1:0] i;
    logic signed [SAMPLE_W-1:0] q;
  } iq_s;
  typedef struct packed {
    logic [15:0] phase;
    logic [SAMPLE_W:0] mag;
  } polar_s;
endpackage : rx_chain_pkg

// [src/rx_baseband_chain_ook_demod.sv]
// Receive baseband: decimation, FIR, DC removal, image filter, CORDIC, strength, demodulators
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module rx_baseband_chain_ook_demod
  import rx_chain_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic adc_i,
  input wire logic adc_q,
  input wire logic synth_start,
  output logic cal_inject,
  output logic [7:0] lo_offset_div,
  output logic fsk_data,
  output logic sync_data,
  output logic ook_data,
  output logic [15:0] phase_out
);
  // Configuration registers
  logic [7:0] channel_filter_config;
  logic [1:0] modulation_config;
  logic [15:0] onoff_slicer_config;
  logic [7:0] signal_strength_limit;
  logic [15:0] bit_period;
  logic sync_enable;
  logic [COEF_W-1:0] coef [NUM_TAPS];
  logic [7:0] signal_strength_reading;
  logic strength_valid;
  logic cal_done;
  wire logic [2:0] filter_bw_exponent = channel_filter_config[CFC_EXP_LSB +: 3];
  wire logic [1:0] filter_bw_mantissa = channel_filter_config[CFC_MANT_LSB +: 2];
  wire logic [2:0] offset_removal_cutoff = channel_filter_config[CFC_DCC_LSB +: 3];
  wire logic [7:0] onoff_floor_level = onoff_slicer_config[OSC_FLOOR_LSB +: 8];
  wire logic [2:0] peak_decay_step = onoff_slicer_config[OSC_STEP_LSB +: 3];
  wire logic [2:0] peak_decay_interval = onoff_slicer_config[OSC_INTERVAL_LSB +: 3];
  wire logic [1:0] onoff_threshold_kind = onoff_slicer_config[OSC_KIND_LSB +: 2];
  wire logic is_ook = (modulation_config == MOD_OOK);
  wire logic wr_en = psel && penable && pwrite;
  wire logic rd_en = psel && penable && !pwrite;

  // Bandwidth divisor: mantissa << (exp+2) in FSK, +3 in OOK; halved bandwidth for OOK
  logic [4:0] mant_val;
  always_comb begin
    case (filter_bw_mantissa)
      2'h0: mant_val = MANT16;
      2'h1: mant_val = MANT20;
      default: mant_val = MANT24;
    endcase
  end
  wire logic [3:0] bw_shift = {1'b0, filter_bw_exponent} +
                             (is_ook ? EXP_OFFSET_OOK : EXP_OFFSET_FSK);
  // Shown in the status word so software can see the bandwidth in force
  wire logic [15:0] bw_divisor = 16'(mant_val) << bw_shift;

  // APB writes; bytes beyond the register width are ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_filter_config <= CHANNEL_FILTER_CONFIG_RST;
      modulation_config <= MODULATION_CONFIG_RST;
      onoff_slicer_config <= ONOFF_SLICER_CONFIG_RST;
      signal_strength_limit <= SIGNAL_STRENGTH_LIMIT_RST;
      bit_period <= BIT_PERIOD_RST;
      sync_enable <= 1'b1;
      for (int k = 0; k < NUM_TAPS; k++) coef[k] <= COEF_RST;
    end else if (wr_en && pstrb[0]) begin
      case (paddr)
        ADDR_CHANNEL_FILTER_CONFIG: channel_filter_config <= pwdata[7:0];
        ADDR_MODULATION_CONFIG: begin
          modulation_config <= pwdata[1:0];
          sync_enable <= pwdata[2];
        end
        ADDR_ONOFF_SLICER_CONFIG: onoff_slicer_config <= pwdata[15:0];
        ADDR_SIGNAL_STRENGTH_LIMIT: signal_strength_limit <= pwdata[7:0];
        ADDR_BIT_PERIOD: bit_period <= pwdata[15:0];
        default: begin
          if (paddr[7:6] == ADDR_COEF_BASE[7:6] && paddr[1:0] == 2'h0)
            coef[paddr[5:2]] <= pwdata[COEF_W-1:0];
        end
      endcase
    end
  end

  // APB read mux; unmapped addresses answer with an error, zero-wait
  logic [31:0] next_prdata;
  logic next_err;
  always_comb begin
    next_prdata = 32'h0;
    next_err = 1'b0;
    case (paddr)
      ADDR_CHANNEL_FILTER_CONFIG: next_prdata = {24'h0, channel_filter_config};
      ADDR_MODULATION_CONFIG: next_prdata = {29'h0, sync_enable, modulation_config};
      ADDR_ONOFF_SLICER_CONFIG: next_prdata = {16'h0, onoff_slicer_config};
      ADDR_SIGNAL_STRENGTH_LIMIT: next_prdata = {24'h0, signal_strength_limit};
      ADDR_SIGNAL_STRENGTH_READING:
        next_prdata = {24'h0, strength_valid ? signal_strength_reading : 8'h00};
      ADDR_STATUS: next_prdata = {bw_divisor, 14'h0, cal_done, strength_valid};
      ADDR_BIT_PERIOD: next_prdata = {16'h0, bit_period};
      default: begin
        if (paddr[7:6] == ADDR_COEF_BASE[7:6] && paddr[1:0] == 2'h0)
          next_prdata = {{(32-COEF_W){1'b0}}, coef[paddr[5:2]]};
        else
          next_err = 1'b1;
      end
    endcase
  end

  // Registered answer: pready rises in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && next_err;
      prdata <= (psel && !penable && !pwrite) ? next_prdata : prdata;
    end
  end

  // Decimator: boxcar of one-bit streams into signed counts
  logic [3:0] dec_cnt;
  logic signed [SAMPLE_W-1:0] acc_i, acc_q;
  iq_s dec_s;
  logic dec_v;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dec_cnt <= 4'h0;
      acc_i <= '0;
      acc_q <= '0;
      dec_s <= '0;
      dec_v <= 1'b0;
    end else begin
      dec_v <= (dec_cnt == 4'(DECIM_LEN - 1));
      if (dec_cnt == 4'(DECIM_LEN - 1)) begin
        dec_cnt <= 4'h0;
        dec_s.i <= acc_i + (adc_i ? 12'sh001 : -12'sh001);
        dec_s.q <= acc_q + (adc_q ? 12'sh001 : -12'sh001);
        acc_i <= '0;
        acc_q <= '0;
      end else begin
        dec_cnt <= dec_cnt + 4'h1;
        acc_i <= acc_i + (adc_i ? 12'sh001 : -12'sh001);
        acc_q <= acc_q + (adc_q ? 12'sh001 : -12'sh001);
      end
    end
  end

  // Sixteen-tap FIR, sixteen parallel multiplies per path, sums all taps per sample
  iq_s taps [NUM_TAPS];
  logic signed [31:0] fir_i, fir_q;
  always_comb begin
    fir_i = '0;
    fir_q = '0;
    for (int k = 0; k < NUM_TAPS; k++) begin
      fir_i = fir_i + 32'(taps[k].i * $signed({1'b0, coef[k]}));
      fir_q = fir_q + 32'(taps[k].q * $signed({1'b0, coef[k]}));
    end
  end
  iq_s fir_s;
  logic fir_v;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < NUM_TAPS; k++) taps[k] <= '0;
      fir_s <= '0;
      fir_v <= 1'b0;
    end else begin
      fir_v <= dec_v;
      if (dec_v) begin
        taps[0] <= dec_s;
        for (int k = 1; k < NUM_TAPS; k++) taps[k] <= taps[k-1];
        fir_s.i <= fir_i[SAMPLE_W+7:8];
        fir_s.q <= fir_q[SAMPLE_W+7:8];
      end
    end
  end

  // DC removal: high-pass with pole shift from cutoff code plus bandwidth exponent
  wire logic [4:0] dcc_shift = 5'(DCC_SHIFT_BASE) + 5'(offset_removal_cutoff) +
                               5'(filter_bw_exponent);
  logic signed [SAMPLE_W+15:0] dc_i, dc_q;
  iq_s hp_s;
  logic hp_v;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dc_i <= '0;
      dc_q <= '0;
      hp_s <= '0;
      hp_v <= 1'b0;
    end else begin
      hp_v <= fir_v;
      if (fir_v) begin
        hp_s.i <= fir_s.i - SAMPLE_W'(dc_i >>> 16);
        hp_s.q <= fir_s.q - SAMPLE_W'(dc_q >>> 16);
        // Only the error term is shifted, else the pole collapses to a plain copy
        dc_i <= dc_i + ((((SAMPLE_W+16)'(fir_s.i) <<< 16) - dc_i) >>> dcc_shift);
        dc_q <= dc_q + ((((SAMPLE_W+16)'(fir_s.q) <<< 16) - dc_q) >>> dcc_shift);
      end
    end
  end

  // Quarter-rate rotation count (rot, not applied to the samples), then image filter (OOK only)
  logic [1:0] rot;
  iq_s img_s, img_prev;
  logic img_v;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rot <= 2'h0;
      img_s <= '0;
      img_prev <= '0;
      img_v <= 1'b0;
    end else begin
      img_v <= hp_v;
      if (hp_v) begin
        rot <= rot + 2'h1;
        if (!is_ook) begin
          img_s <= hp_s;
        end else begin
          img_prev <= hp_s;
          // Averaging with the previous sample attenuates the mirror sideband
          img_s.i <= SAMPLE_W'((13'(hp_s.i) + 13'(img_prev.q)) >>> 1);
          img_s.q <= SAMPLE_W'((13'(hp_s.q) - 13'(img_prev.i)) >>> 1);
        end
      end
    end
  end

  // IF offset handed to synthesizer: bandwidth shift plus one (divisor doubled) in OOK, zero in FSK
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lo_offset_div <= 8'h0;
    else lo_offset_div <= is_ook ? 8'(bw_shift + 4'h1) : 8'h0;
  end

  // CORDIC vectoring, iterative, one micro-rotation per clock
  logic signed [SAMPLE_W+1:0] cx, cy;
  logic signed [15:0] cz;
  logic [3:0] citer;
  logic cbusy;
  polar_s polar;
  logic polar_v;
  logic signed [15:0] atan_lut [12];
  assign atan_lut = '{16'sd8192, 16'sd4836, 16'sd2555, 16'sd1297, 16'sd651, 16'sd326,
                      16'sd163, 16'sd81, 16'sd41, 16'sd20, 16'sd10, 16'sd5};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cx <= '0;
      cy <= '0;
      cz <= '0;
      citer <= 4'h0;
      cbusy <= 1'b0;
      polar <= '0;
      polar_v <= 1'b0;
    end else begin
      polar_v <= 1'b0;
      if (img_v && !cbusy) begin
        cbusy <= 1'b1;
        citer <= 4'h0;
        cx <= img_s.i[SAMPLE_W-1] ? -(SAMPLE_W+2)'(img_s.i) : (SAMPLE_W+2)'(img_s.i);
        cy <= img_s.i[SAMPLE_W-1] ? -(SAMPLE_W+2)'(img_s.q) : (SAMPLE_W+2)'(img_s.q);
        cz <= img_s.i[SAMPLE_W-1] ? 16'sh8000 : 16'sh0000;
      end else if (cbusy) begin
        if (cy >= 0) begin
          cx <= cx + (cy >>> citer);
          cy <= cy - (cx >>> citer);
          cz <= cz + atan_lut[citer];
        end else begin
          cx <= cx - (cy >>> citer);
          cy <= cy + (cx >>> citer);
          cz <= cz - atan_lut[citer];
        end
        citer <= citer + 4'h1;
        if (citer == 4'd11) begin
          cbusy <= 1'b0;
          polar_v <= 1'b1;
          polar.phase <= cz;
          polar.mag <= (SAMPLE_W+1)'(cx);
        end
      end
    end
  end

  // FSK demod: sign of phase difference, optionally retimed at bit rate
  logic [15:0] last_phase;
  logic [15:0] bit_cnt;
  wire logic [15:0] phase_step = polar.phase - last_phase;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_phase <= 16'h0;
      fsk_data <= 1'b0;
      phase_out <= 16'h0;
      sync_data <= 1'b0;
      bit_cnt <= 16'h0;
    end else begin
      bit_cnt <= (bit_cnt >= bit_period) ? 16'h0 : bit_cnt + 16'h1;
      if (polar_v) begin
        last_phase <= polar.phase;
        phase_out <= polar.phase;
        fsk_data <= ~phase_step[15];
      end
      if (bit_cnt == 16'h0)
        sync_data <= sync_enable ? fsk_data : 1'b0;
    end
  end

  // Strength: log2 magnitude in half-dB units, latched every two bit periods
  logic [7:0] log_mag;
  always_comb begin
    log_mag = 8'h0;
    for (int k = 0; k <= SAMPLE_W; k++)
      if (polar.mag[k]) log_mag = 8'(k * 12) + 8'(polar.mag[k-1 >= 0 ? k-1 : 0] ? 6 : 0);
  end
  logic [7:0] cur_strength;
  logic [1:0] acq_bits;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_strength <= 8'h0;
      acq_bits <= 2'h0;
      signal_strength_reading <= 8'h0;
      strength_valid <= 1'b0;
    end else begin
      if (polar_v) cur_strength <= log_mag;
      if (bit_cnt == 16'h0) begin
        if (acq_bits == 2'(RSSI_ACQ_BITS - 1)) begin
          acq_bits <= 2'h0;
          signal_strength_reading <= cur_strength;
          strength_valid <= cur_strength > signal_strength_limit;
        end else begin
          acq_bits <= acq_bits + 2'h1;
        end
      end
    end
  end
  strength_cadence_a: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(signal_strength_reading) |-> $past(bit_cnt) == 16'h0)
    else $error("strength reading updated off the bit boundary");
  readable_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    strength_valid |-> signal_strength_reading > signal_strength_limit)
    else $error("strength flagged valid below limit");

  // OOK slicer: peak tracker with decay and floor, fixed and average thresholds
  logic [7:0] peak, avg, threshold;
  logic [7:0] decay_cnt;
  wire logic [7:0] decay_len = 8'h1 << peak_decay_interval;
  always_comb begin
    case (onoff_kind_e'(onoff_threshold_kind))
      // Nine-bit sum so a floor near full scale cannot wrap below the peak
      KIND_PEAK: threshold = ({1'b0, peak} > 9'(onoff_floor_level) + 9'(PEAK_DROP_6DB)) ?
                             peak - PEAK_DROP_6DB : onoff_floor_level;
      KIND_AVERAGE: threshold = avg;
      default: threshold = onoff_floor_level;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peak <= 8'h0;
      avg <= 8'h0;
      decay_cnt <= 8'h0;
      ook_data <= 1'b0;
    end else begin
      if (polar_v) begin
        ook_data <= cur_strength > threshold;
        avg <= 8'((11'(avg) * 11'd7 + 11'(cur_strength)) >> 3);
      end
      decay_cnt <= (decay_cnt >= decay_len) ? 8'h0 : decay_cnt + 8'h1;
      if (cur_strength > peak) begin
        peak <= cur_strength;
      end else if (!ook_data && decay_cnt >= decay_len) begin
        peak <= (peak > 8'(peak_decay_step) + 8'h1) ?
                peak - 8'(peak_decay_step) - 8'h1 : 8'h0;
      end
    end
  end
  peak_floor_a: assert property (@(posedge pclk) disable iff (!presetn)
    onoff_threshold_kind == 2'h1 |-> threshold >= onoff_floor_level)
    else $error("peak threshold below floor");
  peak_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
    (onoff_threshold_kind == 2'h1 && {1'b0, peak} >= 9'(onoff_floor_level) + 9'd20)
      |-> threshold == peak - 8'h0C)
    else $error("peak threshold not six dB below peak");
  fixed_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
    onoff_threshold_kind == 2'h0 |-> threshold == onoff_floor_level)
    else $error("fixed threshold mismatch");
  image_bypass_a: assert property (@(posedge pclk) disable iff (!presetn)
    (modulation_config == 2'h0 && $past(hp_v) && $past(modulation_config) == 2'h0)
      |-> img_s == $past(hp_s))
    else $error("image filter not bypassed in FSK");

  // Gain calibration at synthesizer start: inject until the next acquisition start, release
  cal_state_e cal_state;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_state <= CAL_IDLE;
      cal_inject <= 1'b0;
      cal_done <= 1'b0;
    end else begin
      case (cal_state)
        CAL_IDLE: if (synth_start) begin
          cal_state <= CAL_INJECT;
          cal_inject <= 1'b1;
          cal_done <= 1'b0;
        end
        CAL_INJECT: if (bit_cnt == 16'h0 && acq_bits == 2'h0) begin
          cal_state <= CAL_DONE;
          cal_inject <= 1'b0;
          cal_done <= 1'b1;
        end
        CAL_DONE: cal_state <= CAL_IDLE;
        default: cal_state <= CAL_IDLE;
      endcase
    end
  end
  cal_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cal_state == CAL_IDLE && synth_start) |=> cal_inject)
    else $error("calibration did not start");
endmodule : rx_baseband_chain_ook_demod
`default_nettype wire

// [verification/rf_front_model.sv]
// Behavioural model of the mixer and one-bit converters feeding the receiver
`timescale 1ns/1ps
`default_nettype none
module rf_front_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tone_on,
  output logic adc_i,
  output logic adc_q
);
  logic [8:0] cnt;
  // Free-running phase count; converters run from the crystal, not in frames
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 9'h000;
    end else begin
      cnt <= cnt + 9'h001;
    end
  end
  // Tone: slow quadrature square, well inside the boxcar passband of the channel filter
  // Silence gives zero-mean toggling
  assign adc_i = tone_on ? cnt[8] : cnt[0];
  assign adc_q = tone_on ? (cnt[8] ^ cnt[7]) : ~cnt[0];
endmodule : rf_front_model
`default_nettype wire

// [verification/tb_rx_baseband_chain_ook_demod.sv]
// Self-checking bench for the receive baseband with an RF front-end model
`timescale 1ns/1ps
`default_nettype none
module tb_rx_baseband_chain_ook_demod;
  import rx_chain_pkg::*;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic err;} row_s;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, adc_i, adc_q, synth_start = 1'b0, tone_on = 1'b0;
  logic cal_inject, fsk_data, sync_data, ook_data, seen;
  logic [7:0] lo_offset_div;
  logic [15:0] phase_out;
  int bad_count = 0, n_tests = 0, cyc = 0;
  // Register table: reset values, read-back, unmapped places
  row_s rows [0:12] = '{
    '{0, 8'h00, 0, 32'h55, 0}, '{0, 8'h04, 0, 32'h4, 0}, '{0, 8'h08, 0, 32'h4006, 0},
    '{0, 8'h0C, 0, 32'hE4, 0}, '{0, 8'h18, 0, 32'h100, 0}, '{0, 8'h40, 0, 32'h80, 0},
    '{0, 8'h7C, 0, 32'h80, 0}, '{1, 8'h00, 32'hD7, 0, 0}, '{0, 8'h00, 0, 32'hD7, 0},
    '{1, 8'h18, 32'h8, 0, 0}, '{0, 8'h18, 0, 32'h8, 0}, '{0, 8'h80, 0, 32'h0, 1},
    '{1, 8'h20, 32'h1234, 0, 1}};

  rx_baseband_chain_ook_demod DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .adc_i(adc_i), .adc_q(adc_q),
    .synth_start(synth_start), .cal_inject(cal_inject), .lo_offset_div(lo_offset_div),
    .fsk_data(fsk_data), .sync_data(sync_data), .ook_data(ook_data),
    .phase_out(phase_out));
  rf_front_model front (.pclk(pclk), .presetn(presetn), .tone_on(tone_on),
    .adc_i(adc_i), .adc_q(adc_q));

  always #20 pclk = ~pclk;
  // Hang guard, far above the expected few thousand cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk_word

  task automatic chk_bit(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick

  // One APB transfer; the idle edge first keeps release and next setup apart
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the hang guard ends a wait for the answer
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  initial begin
    tick(6);
    presetn <= 1'b1;
    foreach (rows[k]) begin
      apb(rows[k].w, rows[k].a, rows[k].d);
      chk_bit("slverr", rows[k].err, er);
      if (!rows[k].w) chk_word("readback", rows[k].e, rd);
    end
    $display("done register table");
    // FSK with synchroniser off: no IF offset, retimed output quiet after one bit
    apb(1, 8'h04, 32'h0);
    tick(12);
    seen = 1'b0;
    repeat (64) begin
      @(posedge pclk);
      seen = seen | sync_data;
    end
    chk_bit("sync_data", 1'b0, seen);
    chk_word("lo_offset_div", 32'h0, {24'h0, lo_offset_div});
    // Divisor in status[31:16]: mantissa times two to exponent plus two or three
    apb(0, 8'h14, 0);
    chk_word("fsk_divisor", 32'h3000, {16'h0, rd[31:16]});
    apb(1, 8'h04, 32'h5);
    tick(8);
    chk_bit("lo_offset_nonzero", 1'b1, |lo_offset_div);
    chk_word("lo_offset_shift", 32'hB, {24'h0, lo_offset_div});
    apb(0, 8'h14, 0);
    chk_word("ook_divisor", 32'h6000, {16'h0, rd[31:16]});
    apb(1, 8'h00, 32'h48);
    apb(0, 8'h14, 0);
    chk_word("mant20_divisor", 32'hA0, {16'h0, rd[31:16]});
    apb(1, 8'h00, 32'h40);
    apb(0, 8'h14, 0);
    chk_word("mant16_divisor", 32'h80, {16'h0, rd[31:16]});
    apb(1, 8'h00, 32'hD7);
    tick(12);
    chk_bit("sync_follows", fsk_data, sync_data);
    $display("done modulation");
    // Gain calibration started by synthesiser start-up
    synth_start <= 1'b1;
    @(posedge pclk);
    synth_start <= 1'b0;
    seen = 1'b0;
    repeat (200) begin
      @(posedge pclk);
      seen = seen | cal_inject;
    end
    chk_bit("cal_inject", 1'b1, seen);
    for (int n = 0; n < 2000 && cal_inject !== 1'b0; n++) @(posedge pclk);
    apb(0, 8'h14, 0);
    chk_bit("cal_done", 1'b1, rd[1]);
    $display("done calibration");
    // Strength sampled during the slow quadrature tone, limit at both ends
    tone_on <= 1'b1;
    apb(1, 8'h0C, 32'hFF);
    tick(64);
    apb(0, 8'h10, 0);
    chk_word("reading_below_limit", 32'h0, rd);
    apb(1, 8'h0C, 32'h0);
    tick(64);
    apb(0, 8'h14, 0);
    chk_bit("strength_valid", 1'b1, rd[0]);
    apb(0, 8'h10, 0);
    chk_bit("reading_nonzero", 1'b1, |rd);
    // A running tone keeps turning the extracted phase
    rd[15:0] = phase_out;
    tick(20);
    chk_bit("phase_moves", 1'b1, phase_out != rd[15:0]);
    $display("done strength");
    // Slicer kinds: fixed at both floors, peak decay to floor, average
    apb(1, 8'h08, 32'h0000);
    tick(32);
    chk_bit("ook_fixed_low", 1'b1, ook_data);
    apb(1, 8'h08, 32'h00FF);
    tick(32);
    chk_bit("ook_fixed_high", 1'b0, ook_data);
    apb(1, 8'h08, 32'h4010);
    tone_on <= 1'b0;
    tick(400);
    chk_bit("ook_peak_quiet", 1'b0, ook_data);
    tone_on <= 1'b1;
    tick(200);
    chk_bit("ook_peak_tone", 1'b1, ook_data);
    // Average kind: strength rising from silence stays above its own running mean
    apb(1, 8'h08, 32'h80FF);
    tone_on <= 1'b0;
    tick(400);
    tone_on <= 1'b1;
    tick(120);
    chk_bit("ook_avg_rise", 1'b1, ook_data);
    apb(0, 8'h08, 0);
    chk_word("avg_kind", 32'h80FF, rd);
    $display("done slicer");
    // Mid-run reset: outputs clear at once, configuration back to reset values
    presetn <= 1'b0;
    tick(2);
    chk_word("reset_lo_offset", 32'h0, {24'h0, lo_offset_div});
    chk_bit("reset_ook", 1'b0, ook_data);
    presetn <= 1'b1;
    apb(0, 8'h00, 0);
    chk_word("reset_filter_config", 32'h55, rd);
    $display("done reset");
    tally_and_finish();
  end
endmodule : tb_rx_baseband_chain_ook_demod
`default_nettype wire
